// file: hw/msd_decoder.sv
// Chosen here: the AHB-Lite slave port and the placing of the registers.
`timescale 1ns/1ps
// Summary of operation
// - ROM mapping: 0x0..0x1FFFF selects 128 KB on-chip ROM, 32 bits wide.
// - ROM mapping: first region 0x200000..0x3FFFFF; gap below reserved.
// - ROM-less mapping: first region spans 0x0..0x3FFFFF, four megabytes.
// - Both maps: region two 0x400000..0x7FFFFF, three 0x800000..0xBFFFFF.
// - DRAM region from 0x1000000, 16 megabytes, register-chosen width.
// - 0xFFFF8000..0xFFFF87FF goes to peripherals, 8 or 16 bits.
// - 0xFFFFF000 to top goes to on-chip RAM, 32 bits wide.
// - 0x2000000..0xFFFF7FFF is reserved; no external region selected.
// - Single-chip mode leaves only ROM, RAM and peripheral space usable.
// - 64 KB ROM variant decodes ROM to 0xFFFF; next 64 KB reserved.
// - ROM-less mapping takes first region width from the mode pin.
// - Control register resets to 0x200F and keeps contents in standby.
// - Bits 15,14,12..9 read 0; bit 13 reads 1.
// - Bits 7..4 read 0 after reset; software writes them as 0.
// - Bit 8 selects fourth region: 0 ordinary, 1 multiplexed I/O.
// - Multiplexed fourth region puts address then data on shared pins.
// - Multiplexed fourth region width is address bit 14: 0 byte, 1 word.
// - Bit 3 sets fourth region ordinary width; ignored when multiplexed.
// - Bits 2,1,0 set third, second, first region widths (first in ROM mapping only); word at reset.
module msd_decoder #(
  parameter bit ROM_64K = 1'b0
) (
  // Clock and reset.
  input  wire logic                  clk,
  input  wire logic                  srst,
  // AHB-Lite register slave.
  input  wire logic                  hsel,
  input  wire logic [31:0]           haddr,
  input  wire logic [1:0]            htrans,
  input  wire logic                  hwrite,
  input  wire logic [2:0]            hsize,
  input  wire logic [31:0]           hwdata,
  input  wire logic                  hready,
  output logic                       hreadyout,
  output logic                       hresp,
  output logic [31:0]                hrdata,
  // Operating mode inputs.
  input  wire logic                  rom_enable_mode,
  input  wire logic                  single_chip_mode,
  input  wire logic                  boot_width16_pin,
  // CPU access request.
  input  wire logic                  cpu_valid,
  input  wire logic [31:0]           cpu_addr,
  input  wire logic [15:0]           cpu_wdata,
  output logic                       mux_busy,
  // Decoded selection.
  output logic                       sel_rom,
  output logic                       select_region_first,
  output logic                       select_region_second,
  output logic                       select_region_third,
  output logic                       select_region_fourth,
  output logic                       sel_dram,
  output logic                       sel_periph,
  output logic                       sel_ram,
  output logic                       sel_reserved,
  output logic [1:0]                 access_width,
  // Multiplexed data bus.
  output logic [15:0]                mux_data_out,
  output logic                       mux_data_oe_n,
  output logic                       addr_hold_n
);
  import msd_pkg::*;

  logic [15:0]    ctrl_reg;
  logic           rom_mode_reg;
  logic           single_reg;
  logic           boot16_reg;
  logic           wr_pend_reg;
  logic [3:0]     region_next;
  logic [3:0]     region_reg;
  logic [1:0]     width_next;
  msd_mux_state_t mx_reg;
  logic [15:0]    mx_wdata_reg;
  logic           ahb_take;

  function automatic logic [3:0] decode(input logic [31:0] a,
                                        input logic        rom_on,
                                        input logic        single);
    logic [31:0] rom_top;
    logic [3:0]  r;
    rom_top = ROM_64K ? MSD_ROM64_TOP : MSD_ROM128_TOP;
    r = MSD_RG_RSVD;
    if (rom_on && a <= rom_top) begin
      r = MSD_RG_ROM;
    end else if (rom_on && a < MSD_CS0_BASE_E) begin
      r = MSD_RG_RSVD;
    end else if (a <= MSD_CS0_TOP) begin
      r = MSD_RG_CS0;
    end else if (a <= MSD_CS1_TOP) begin
      r = MSD_RG_CS1;
    end else if (a <= MSD_CS2_TOP) begin
      r = MSD_RG_CS2;
    end else if (a <= MSD_CS3_TOP) begin
      r = MSD_RG_CS3;
    end else if (a <= MSD_DRAM_TOP) begin
      r = MSD_RG_DRAM;
    end else if (a >= MSD_PERI_BASE && a <= MSD_PERI_TOP) begin
      r = MSD_RG_PERI;
    end else if (a >= MSD_RAM_BASE) begin
      r = MSD_RG_RAM;
    end
    // External spaces vanish in single-chip mode.
    if (single && r != MSD_RG_ROM && r != MSD_RG_PERI && r != MSD_RG_RAM)
    begin
      r = MSD_RG_RSVD;
    end
    return r;
  endfunction : decode

  function automatic logic [1:0] bit_width(input logic wide);
    return wide ? MSD_W16 : MSD_W8;
  endfunction : bit_width

  // Mode straps are caught while reset is held, so they stay fixed after.
  always_ff @(posedge clk) begin
    if (srst) begin
      rom_mode_reg <= rom_enable_mode;
      single_reg   <= single_chip_mode;
      boot16_reg   <= boot_width16_pin;
    end
  end

  // AHB-Lite slave: zero wait states, always OKAY.
  assign hreadyout = 1'b1;
  assign hresp     = 1'b0;
  assign ahb_take  = hsel && hready && htrans == MSD_HTRANS_NONSEQ &&
                     haddr == MSD_CTRL_OFFSET;

  always_ff @(posedge clk) begin
    if (srst) begin
      wr_pend_reg <= 1'b0;
    end else if (hready) begin
      wr_pend_reg <= ahb_take && hwrite;
    end
  end

  // Writes keep only writable bits; fixed bits are forced as the value is stored.
  always_ff @(posedge clk) begin
    if (srst) begin
      ctrl_reg <= MSD_CTRL_RESET;
    end else if (wr_pend_reg) begin
      ctrl_reg <= (hwdata[15:0] & MSD_CTRL_RW_MASK) |
                  MSD_CTRL_RO_ONES;
    end
  end

  // Read data is registered in the address phase; unmapped words read zero.
  always_ff @(posedge clk) begin
    if (srst) begin
      hrdata <= 32'h0000_0000;
    end else if (hready) begin
      if (ahb_take && !hwrite) begin
        hrdata <= {16'h0000, ctrl_reg};
      end else begin
        hrdata <= 32'h0000_0000;
      end
    end
  end

  // Width selection per region.
  always_comb begin
    region_next = decode(cpu_addr, rom_mode_reg, single_reg);
    width_next  = MSD_W_NONE;
    case (region_next)
      MSD_RG_ROM:  width_next = MSD_W32;
      MSD_RG_RAM:  width_next = MSD_W32;
      MSD_RG_PERI: width_next = cpu_addr[0] ? MSD_W8 : MSD_W16;
      MSD_RG_CS0:  width_next = rom_mode_reg ? bit_width(ctrl_reg[MSD_W0_BIT])
                     : bit_width(boot16_reg);
      MSD_RG_CS1:  width_next = bit_width(ctrl_reg[MSD_W1_BIT]);
      MSD_RG_CS2:  width_next = bit_width(ctrl_reg[MSD_W2_BIT]);
      MSD_RG_CS3:  width_next = ctrl_reg[MSD_MUX_BIT]
                     ? bit_width(cpu_addr[MSD_MUX_WBIT])
                     : bit_width(ctrl_reg[MSD_W3_BIT]);
      MSD_RG_DRAM: width_next = bit_width(ctrl_reg[MSD_W0_BIT]);
      default:     width_next = MSD_W_NONE;
    endcase
  end

  // DRAM width really lives in the DRAM controller; the first region's bit
  // is a stand-in here since that controller is outside this block.
  always_ff @(posedge clk) begin
    if (srst) begin
      region_reg   <= MSD_RG_RSVD;
      access_width <= MSD_W_NONE;
    end else if (cpu_valid) begin
      region_reg   <= region_next;
      access_width <= width_next;
    end else begin
      region_reg   <= MSD_RG_RSVD;
      access_width <= MSD_W_NONE;
    end
  end

  // Reserved flag is raised only for a real access into a hole.
  logic rsvd_reg;
  always_ff @(posedge clk) begin
    if (srst) begin
      rsvd_reg <= 1'b0;
    end else begin
      rsvd_reg <= cpu_valid && region_next == MSD_RG_RSVD;
    end
  end

  assign sel_rom              = region_reg == MSD_RG_ROM;
  assign select_region_first  = region_reg == MSD_RG_CS0;
  assign select_region_second = region_reg == MSD_RG_CS1;
  assign select_region_third  = region_reg == MSD_RG_CS2;
  assign select_region_fourth = region_reg == MSD_RG_CS3;
  assign sel_dram             = region_reg == MSD_RG_DRAM;
  assign sel_periph           = region_reg == MSD_RG_PERI;
  assign sel_ram              = region_reg == MSD_RG_RAM;
  assign sel_reserved         = rsvd_reg;

  // Multiplexed sequencer: address phase then data phase on the shared pins.
  always_ff @(posedge clk) begin
    if (srst) begin
      mx_reg       <= MSD_MX_IDLE;
      mx_wdata_reg <= 16'h0000;
      mux_data_out <= 16'h0000;
    end else begin
      case (mx_reg)
        MSD_MX_IDLE: begin
          if (cpu_valid && region_next == MSD_RG_CS3 &&
              ctrl_reg[MSD_MUX_BIT]) begin
            mx_reg       <= MSD_MX_ADDR;
            mux_data_out <= cpu_addr[15:0];
            mx_wdata_reg <= cpu_wdata;
          end
        end
        MSD_MX_ADDR: begin
          mx_reg       <= MSD_MX_DATA;
          mux_data_out <= mx_wdata_reg;
        end
        default: begin
          mx_reg <= MSD_MX_IDLE;
        end
      endcase
    end
  end

  assign mux_busy      = mx_reg != MSD_MX_IDLE;
  assign mux_data_oe_n = !(mx_reg == MSD_MX_ADDR || mx_reg == MSD_MX_DATA);
  assign addr_hold_n   = !(mx_reg == MSD_MX_ADDR);

  // Checks.
  property p_rom_sel;
    @(posedge clk) disable iff (srst)
    cpu_valid && rom_mode_reg && !ROM_64K && cpu_addr <= MSD_ROM128_TOP
    |=> sel_rom && access_width == MSD_W32;
  endproperty
  a_rom_sel: assert property (p_rom_sel)
    else $error("rom decode wrong");

  property p_cs0_gap;
    @(posedge clk) disable iff (srst)
    cpu_valid && rom_mode_reg && cpu_addr > MSD_ROM128_TOP &&
    cpu_addr < MSD_CS0_BASE_E |=> sel_reserved && !select_region_first;
  endproperty
  a_cs0_gap: assert property (p_cs0_gap)
    else $error("rom gap not reserved");

  property p_cs0_romless;
    @(posedge clk) disable iff (srst)
    cpu_valid && !rom_mode_reg && !single_reg && cpu_addr <= MSD_CS0_TOP
    |=> select_region_first && access_width == bit_width($past(boot16_reg));
  endproperty
  a_cs0_romless: assert property (p_cs0_romless)
    else $error("cs0 wrong");

  property p_cs1;
    @(posedge clk) disable iff (srst)
    cpu_valid && !single_reg && cpu_addr > MSD_CS0_TOP &&
    cpu_addr <= MSD_CS1_TOP |=> select_region_second;
  endproperty
  a_cs1: assert property (p_cs1)
    else $error("second region missed");

  property p_hole;
    @(posedge clk) disable iff (srst)
    cpu_valid && cpu_addr > MSD_DRAM_TOP && cpu_addr < MSD_PERI_BASE
    |=> sel_reserved && access_width == MSD_W_NONE;
  endproperty
  a_hole: assert property (p_hole)
    else $error("hole selected");

  property p_single;
    @(posedge clk) disable iff (srst)
    single_reg |-> !(select_region_first || select_region_second ||
                     select_region_third || select_region_fourth || sel_dram);
  endproperty
  a_single: assert property (p_single)
    else $error("external in single");

  property p_ram;
    @(posedge clk) disable iff (srst)
    cpu_valid && cpu_addr >= MSD_RAM_BASE
    |=> sel_ram && access_width == MSD_W32;
  endproperty
  a_ram: assert property (p_ram)
    else $error("ram decode wrong");

  property p_fixed_bits;
    @(posedge clk) disable iff (srst)
    ctrl_reg[15:9] == 7'b0010000;
  endproperty
  a_fixed_bits: assert property (p_fixed_bits)
    else $error("fixed bits bad");

  property p_mux_seq;
    @(posedge clk) disable iff (srst)
    mx_reg == MSD_MX_IDLE && cpu_valid && region_next == MSD_RG_CS3 &&
    ctrl_reg[MSD_MUX_BIT]
    |=> !addr_hold_n && mux_data_out == $past(cpu_addr[15:0])
    ##1 addr_hold_n && !mux_data_oe_n ##1 mux_data_oe_n;
  endproperty
  a_mux_seq: assert property (p_mux_seq)
    else $error("mux sequence bad");

  property p_mux_width;
    @(posedge clk) disable iff (srst)
    cpu_valid && region_next == MSD_RG_CS3 && ctrl_reg[MSD_MUX_BIT]
    |=> access_width == ($past(cpu_addr[MSD_MUX_WBIT]) ? MSD_W16 : MSD_W8);
  endproperty
  a_mux_width: assert property (p_mux_width)
    else $error("mux width bad");

  // Unused low field must never hold a one, whatever was written.
  property p_loose_bits;
    @(posedge clk) disable iff (srst)
    ctrl_reg[7:4] == 4'h0;
  endproperty
  a_loose_bits: assert property (p_loose_bits)
    else $error("loose bits set");

  property p_cs3_plain;
    @(posedge clk) disable iff (srst)
    cpu_valid && !single_reg && cpu_addr > MSD_CS2_TOP &&
    cpu_addr <= MSD_CS3_TOP && !ctrl_reg[MSD_MUX_BIT]
    |=> select_region_fourth &&
        access_width == ($past(ctrl_reg[MSD_W3_BIT]) ? MSD_W16 : MSD_W8);
  endproperty
  a_cs3_plain: assert property (p_cs3_plain)
    else $error("fourth region width wrong");

endmodule : msd_decoder

// file: hw/msd_pkg.sv
package msd_pkg;

  // Register window on the AHB-Lite port.
  localparam logic [31:0] MSD_CTRL_OFFSET  = 32'h0000_0000;
  localparam logic [15:0] MSD_CTRL_RESET   = 16'h200F;
  localparam logic [15:0] MSD_CTRL_RO_ONES = 16'h2000;
  localparam logic [15:0] MSD_CTRL_RW_MASK = 16'h010F;

  // Field positions of the control register.
  localparam int MSD_MUX_BIT = 8;
  localparam int MSD_W3_BIT  = 3;
  localparam int MSD_W2_BIT  = 2;
  localparam int MSD_W1_BIT  = 1;
  localparam int MSD_W0_BIT  = 0;

  // Address map boundaries.
  localparam logic [31:0] MSD_ROM128_TOP = 32'h0001_FFFF;
  localparam logic [31:0] MSD_ROM64_TOP  = 32'h0000_FFFF;
  localparam logic [31:0] MSD_CS0_BASE_E = 32'h0020_0000;
  localparam logic [31:0] MSD_CS0_TOP    = 32'h003F_FFFF;
  localparam logic [31:0] MSD_CS1_TOP    = 32'h007F_FFFF;
  localparam logic [31:0] MSD_CS2_TOP    = 32'h00BF_FFFF;
  localparam logic [31:0] MSD_CS3_TOP    = 32'h00FF_FFFF;
  localparam logic [31:0] MSD_DRAM_TOP   = 32'h01FF_FFFF;
  localparam logic [31:0] MSD_PERI_BASE  = 32'hFFFF_8000;
  localparam logic [31:0] MSD_PERI_TOP   = 32'hFFFF_87FF;
  localparam logic [31:0] MSD_RAM_BASE   = 32'hFFFF_F000;
  localparam int          MSD_MUX_WBIT   = 14;

  // Region codes.
  localparam logic [3:0] MSD_RG_RSVD = 4'h0;
  localparam logic [3:0] MSD_RG_ROM  = 4'h1;
  localparam logic [3:0] MSD_RG_CS0  = 4'h2;
  localparam logic [3:0] MSD_RG_CS1  = 4'h3;
  localparam logic [3:0] MSD_RG_CS2  = 4'h4;
  localparam logic [3:0] MSD_RG_CS3  = 4'h5;
  localparam logic [3:0] MSD_RG_DRAM = 4'h6;
  localparam logic [3:0] MSD_RG_PERI = 4'h7;
  localparam logic [3:0] MSD_RG_RAM  = 4'h8;

  // Access width codes.
  localparam logic [1:0] MSD_W_NONE = 2'h0;
  localparam logic [1:0] MSD_W8     = 2'h1;
  localparam logic [1:0] MSD_W16    = 2'h2;
  localparam logic [1:0] MSD_W32    = 2'h3;

  // AHB transfer types.
  localparam logic [1:0] MSD_HTRANS_NONSEQ = 2'h2;

  typedef enum logic [2:0] {
    MSD_MX_IDLE = 3'b001,
    MSD_MX_ADDR = 3'b010,
    MSD_MX_DATA = 3'b100
  } msd_mux_state_t;

endpackage : msd_pkg

// file: testbench/msd_mux_device.sv
`timescale 1ns/1ps
module msd_mux_device (
  // Clock.
  input  wire logic        clk,
  // Multiplexed bus from the decoder.
  input  wire logic        addr_hold_n,
  input  wire logic        oe_n,
  input  wire logic [15:0] bus,
  // What the device latched.
  output logic      [15:0] got_addr,
  output logic      [15:0] got_data
);
  // The hold strobe marks the address cycle; data follows while driven.
  always_ff @(posedge clk) begin
    if (!addr_hold_n && !oe_n) begin
      got_addr <= bus;
    end else if (!oe_n) begin
      got_data <= bus;
    end
  end
endmodule : msd_mux_device

// file: testbench/memory_space_decoder_test.sv
`timescale 1ns/1ps
module memory_space_decoder_test import msd_pkg::*;;
  logic        clk = 0, srst = 1, hwrite = 0, rom_en = 1, single = 0;
  logic        w16 = 1, cpu_valid = 0, hreadyout, hresp, mux_busy;
  logic [31:0] haddr = 0, hwdata = 0, hrdata, cpu_addr = 0, rd;
  logic [1:0]  htrans = 0, access_width;
  logic [2:0]  hsize = 0;
  logic [15:0] cpu_wdata = 0, mux_data_out, got_addr, got_data;
  logic [8:0]  sel;
  logic        mux_data_oe_n, addr_hold_n;
  int          err_count = 0, checked = 0, cyc = 0;

  always #5 clk = ~clk;

  msd_decoder #(.ROM_64K(1'b0)) dut_u (.clk(clk), .srst(srst), .hsel(1'b1),
    .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize),
    .hwdata(hwdata), .hready(hreadyout), .hreadyout(hreadyout),
    .hresp(hresp), .hrdata(hrdata), .rom_enable_mode(rom_en),
    .single_chip_mode(single), .boot_width16_pin(w16),
    .cpu_valid(cpu_valid), .cpu_addr(cpu_addr), .cpu_wdata(cpu_wdata),
    .mux_busy(mux_busy), .sel_rom(sel[8]), .select_region_first(sel[7]),
    .select_region_second(sel[6]), .select_region_third(sel[5]),
    .select_region_fourth(sel[4]), .sel_dram(sel[3]),
    .sel_periph(sel[2]), .sel_ram(sel[1]), .sel_reserved(sel[0]),
    .access_width(access_width), .mux_data_out(mux_data_out),
    .mux_data_oe_n(mux_data_oe_n), .addr_hold_n(addr_hold_n));

  msd_mux_device part_u (.clk(clk), .addr_hold_n(addr_hold_n),
    .oe_n(mux_data_oe_n), .bus(mux_data_out), .got_addr(got_addr),
    .got_data(got_data));

  task automatic test_done();
    $display("Comparisons %0d, mismatches %0d", checked, err_count);
    if (err_count == 0 && checked > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask : test_done

  // A hung handshake would otherwise stall the run forever.
  always @(posedge clk) begin
    cyc++;
    if (cyc > 5000) begin
      err_count++;
      test_done();
    end
  end

  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    checked++;
    if (seen !== exp) begin
      err_count++;
      $display("[ERR] t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask : chk

  task automatic do_reset(input logic r, input logic s, input logic w);
    @(posedge clk);
    srst   <= 1'b1;
    rom_en <= r;
    single <= s;
    w16    <= w;
    repeat (16) @(posedge clk);
    srst <= 1'b0;
  endtask : do_reset

  task automatic ahb(input logic wr, input logic [31:0] a,
                     input logic [31:0] d);
    @(posedge clk);
    htrans <= MSD_HTRANS_NONSEQ;
    haddr  <= a;
    hwrite <= wr;
    hsize  <= 3'h2;
    @(posedge clk);
    while (hreadyout !== 1'b1) @(posedge clk);
    htrans <= 2'h0;
    hwdata <= d;
    @(posedge clk);
    while (hreadyout !== 1'b1) @(posedge clk);
    rd = hrdata;
  endtask : ahb

  task automatic access(input logic [31:0] a, input logic [15:0] d);
    @(posedge clk);
    cpu_valid <= 1'b1;
    cpu_addr  <= a;
    cpu_wdata <= d;
    @(posedge clk);
    cpu_valid <= 1'b0;
    #1;
  endtask : access

  task automatic dec(input logic [31:0] a, input logic [8:0] ev,
                     input logic [1:0] ew);
    access(a, 16'h0000);
    chk({23'h0, sel}, {23'h0, ev});
    chk({30'h0, access_width}, {30'h0, ew});
  endtask : dec

  task automatic t_reg();
    ahb(1'b0, 32'h0000_0000, 32'h0000_0000);
    chk(rd, 32'h0000_200F);
    chk({31'h0, hresp}, 32'h0);
    ahb(1'b0, 32'h0000_0004, 32'h0000_0000);
    chk(rd, 32'h0000_0000);
    ahb(1'b1, 32'h0000_0004, 32'hFFFF_FFFF);
    ahb(1'b0, 32'h0000_0004, 32'h0000_0000);
    chk(rd, 32'h0000_0000);
    ahb(1'b0, 32'h0000_0000, 32'h0000_0000);
    chk(rd, 32'h0000_200F);
    // The one set-up write keeps fixed ones and the unused field as required.
    ahb(1'b1, 32'h0000_0000, 32'h0000_2102);
    ahb(1'b0, 32'h0000_0000, 32'h0000_0000);
    chk(rd, 32'h0000_2102);
  endtask : t_reg

  task automatic t_map_rom();
    dec(32'h0000_0000, 9'h100, MSD_W32);
    dec(32'h0001_FFFF, 9'h100, MSD_W32);
    dec(32'h0002_0000, 9'h001, MSD_W_NONE);
    dec(32'h0020_0000, 9'h080, MSD_W16);
    dec(32'h003F_FFFF, 9'h080, MSD_W16);
    dec(32'h0040_0000, 9'h040, MSD_W16);
    dec(32'h00BF_FFFF, 9'h020, MSD_W16);
    dec(32'h00C0_0000, 9'h010, MSD_W16);
    dec(32'h01FF_FFFF, 9'h008, MSD_W16);
    // Holes are probed for the reserved flag and no width; no data moves.
    dec(32'h0200_0000, 9'h001, MSD_W_NONE);
    dec(32'hFFFF_7FFF, 9'h001, MSD_W_NONE);
    dec(32'hFFFF_8000, 9'h004, MSD_W16);
    dec(32'hFFFF_87FF, 9'h004, MSD_W8);
    dec(32'hFFFF_8800, 9'h001, MSD_W_NONE);
    dec(32'hFFFF_FFFF, 9'h002, MSD_W32);
  endtask : t_map_rom

  task automatic mux_acc(input logic [31:0] a, input logic [15:0] d,
                         input logic [1:0] ew);
    access(a, d);
    chk({29'h0, addr_hold_n, mux_data_oe_n, mux_busy}, 32'h1);
    chk({16'h0, mux_data_out}, {16'h0, a[15:0]});
    chk({23'h0, sel}, 32'h10);
    chk({30'h0, access_width}, {30'h0, ew});
    @(posedge clk);
    #1;
    chk({16'h0, mux_data_out}, {16'h0, d});
    @(posedge clk);
    #1;
    chk({29'h0, addr_hold_n, mux_data_oe_n, mux_busy}, 32'h6);
    chk({got_addr, got_data}, {a[15:0], d});
  endtask : mux_acc

  task automatic t_widths_mux();
    dec(32'h0020_0000, 9'h080, MSD_W8);
    dec(32'h0040_0000, 9'h040, MSD_W16);
    dec(32'h0080_0000, 9'h020, MSD_W8);
    dec(32'h0100_0000, 9'h008, MSD_W8);
    mux_acc(32'h00C0_4000, 16'hA5C3, MSD_W16);
    mux_acc(32'h00C0_1234, 16'h5A3C, MSD_W8);
  endtask : t_widths_mux

  task automatic t_romless();
    do_reset(1'b0, 1'b0, 1'b0);
    rom_en <= 1'b1;
    dec(32'h0000_0000, 9'h080, MSD_W8);
    dec(32'h003F_FFFF, 9'h080, MSD_W8);
    ahb(1'b0, 32'h0000_0000, 32'h0000_0000);
    chk(rd, 32'h0000_200F);
    ahb(1'b1, 32'h0000_0000, 32'h0000_200A);
    dec(32'h00C0_0000, 9'h010, MSD_W16);
    dec(32'h0040_0000, 9'h040, MSD_W16);
  endtask : t_romless

  task automatic t_single();
    do_reset(1'b1, 1'b1, 1'b1);
    dec(32'h0040_0000, 9'h001, MSD_W_NONE);
    dec(32'h0000_0000, 9'h100, MSD_W32);
    dec(32'hFFFF_F000, 9'h002, MSD_W32);
  endtask : t_single

  initial begin
    do_reset(1'b1, 1'b0, 1'b1);
    t_map_rom();
    t_reg();
    t_widths_mux();
    t_romless();
    t_single();
    test_done();
  end
endmodule : memory_space_decoder_test
